/* File: hw/mpp_consts.vh */
// register map, field positions and reset values of the parallel port set
// assumes a 32-bit apb slave, one aligned word per register
`ifndef MPP_CONSTS_VH
`define MPP_CONSTS_VH
`define MPP_ADDR_W 8
`define MPP_OFS_C_CFG 8'h00
`define MPP_OFS_C_DATA 8'h04
`define MPP_OFS_C_PIN 8'h08
`define MPP_OFS_G_CFG 8'h0C
`define MPP_OFS_G_DATA 8'h10
`define MPP_OFS_G_PIN 8'h14
`define MPP_OFS_L_CFG 8'h18
`define MPP_OFS_L_DATA 8'h1C
`define MPP_OFS_L_PIN 8'h20
`define MPP_OFS_D_DATA 8'h24
`define MPP_OFS_I_PIN 8'h28
`define MPP_OFS_STATUS 8'h2C
`define MPP_CFG_RST 8'h00
`define MPP_DATA_RST 8'h00
`define MPP_D_RST 8'hFF
`define MPP_G_STOP_BIT 7
`define MPP_G_IDLE_BIT 6
`define MPP_G_ALTPH_BIT 6
`define MPP_G_DLY_BIT 7
`define MPP_G_SUP_BIT 1
`define MPP_ST_STOP_BIT 0
`define MPP_ST_IDLE_BIT 1
`endif

/* File: hw/mpp_pin_cell.v */
// one bidirectional port: mode decode per bit from config/data
// assumes the pad resolves drive from out/oe_n and pull-up request
`timescale 1ns/1ps
`default_nettype none
module mpp_pin_cell (
  input wire [7:0] cfg_i,
  input wire [7:0] data_i,
  output wire [7:0] out_o,
  output wire [7:0] oe_n_o,
  output wire [7:0] pullup_o
);
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1)
    begin : g_bit
      // cfg=1 drives data; cfg=0 input, data selects weak pull-up
      assign out_o[b] = data_i[b];
      assign oe_n_o[b] = ~cfg_i[b];
      assign pullup_o[b] = ~cfg_i[b] & data_i[b];
    end
  endgenerate
endmodule
`default_nettype wire

/* File: hw/mpp_port_set.v */
// parallel port set: ports c, g, l bidirectional, d output, i input
// assumes apb master, synchronous reset release, external pad logic
// Operation
// - config/data bits pick pin mode
// - each port: config, data, pin addresses (d has only a data address, i only a pin address)
// - data bit 7 of g enters stop
// - data bit 6 of g enters idle
// - g config bit 6 alternate serial phase
// - g config bit 7 enables startup delay with rc option only
// - g data bits 6,7 read zero
// - rc option: g7 input, rise wakes stop
// - crystal option: g7 drives oscillator clock
// - g1 error out, g6 input, g0 and g2-g5 configurable (g7 set by oscillator option)
// - d port all ones during reset
// - l pins feed wakeup and timers 2, 3
// - g alternate serial, timer1, interrupt functions
// - i port input only, feeds converter
// - reset clears c, g, l registers
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ps
`include "mpp_consts.vh"
`default_nettype none
module mpp_port_set (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rc_osc_option_i,
  input wire oscillator_clock_input_i,
  input wire supervisor_error_i,
  input wire stop_exit_i,
  input wire idle_exit_i,
  input wire [7:0] port_c_in_i,
  output reg [7:0] port_c_out_o,
  output reg [7:0] port_c_oe_n_o,
  output reg [7:0] port_c_pullup_o,
  input wire [7:0] port_g_in_i,
  output reg [7:0] port_g_out_o,
  output reg [7:0] port_g_oe_n_o,
  output reg [7:0] port_g_pullup_o,
  input wire [7:0] port_l_in_i,
  output reg [7:0] port_l_out_o,
  output reg [7:0] port_l_oe_n_o,
  output reg [7:0] port_l_pullup_o,
  output reg [7:0] port_d_o,
  input wire [7:0] port_i_in_i,
  output reg [7:0] analog_in_o,
  output reg stop_mode_o,
  output reg idle_mode_o,
  output reg serial_clock_alt_phase_o,
  output reg startup_delay_enable_o,
  output reg serial_data_in_o,
  output reg serial_clock_pin_in_o,
  output reg timer1_io_pin_in_o,
  output reg timer1_capture_pin_o,
  output reg external_interrupt_pin_o,
  output reg [7:0] multi_input_wakeup_o,
  output reg timer2_first_input_o,
  output reg timer2_second_input_o,
  output reg timer3_first_input_o,
  output reg timer3_second_input_o,
  output reg stop_wake_o
);
  reg [7:0] c_cfg;
  reg [7:0] c_data;
  reg [7:0] g_cfg;
  reg [7:0] g_data;
  reg [7:0] l_cfg;
  reg [7:0] l_data;
  reg [7:0] d_data;
  reg stop_req;
  reg idle_req;
  reg g7_prev;
  wire [7:0] c_sync;
  wire [7:0] g_sync;
  wire [7:0] l_sync;
  wire [7:0] i_sync;
  wire [7:0] c_out;
  wire [7:0] c_oe_n;
  wire [7:0] c_pu;
  wire [7:0] g_out;
  wire [7:0] g_oe_n;
  wire [7:0] g_pu;
  wire [7:0] l_out;
  wire [7:0] l_oe_n;
  wire [7:0] l_pu;
  wire [7:0] addr8;
  wire wr_en;
  wire rd_en;
  wire g7_rise;
  reg [7:0] next_rdata;
  reg next_err;
  assign addr8 = paddr[7:0];
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;

  // pin reads pass two flops so a moving pin cannot upset the bus
  mpp_sync #(.W(32)) u_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .async_i({port_i_in_i, port_l_in_i, port_g_in_i, port_c_in_i}),
    .sync_o({i_sync, l_sync, g_sync, c_sync})
  );

  mpp_pin_cell u_cell_c (
    .cfg_i(c_cfg),
    .data_i(c_data),
    .out_o(c_out),
    .oe_n_o(c_oe_n),
    .pullup_o(c_pu)
  );
  mpp_pin_cell u_cell_g (
    .cfg_i(g_cfg),
    .data_i(g_data),
    .out_o(g_out),
    .oe_n_o(g_oe_n),
    .pullup_o(g_pu)
  );
  mpp_pin_cell u_cell_l (
    .cfg_i(l_cfg),
    .data_i(l_data),
    .out_o(l_out),
    .oe_n_o(l_oe_n),
    .pullup_o(l_pu)
  );

  // register writes only at the access phase, pready is high only in the access phase
  always @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      c_cfg <= `MPP_CFG_RST;
      c_data <= `MPP_DATA_RST;
      g_cfg <= `MPP_CFG_RST;
      g_data <= `MPP_DATA_RST;
      l_cfg <= `MPP_CFG_RST;
      l_data <= `MPP_DATA_RST;
      d_data <= `MPP_D_RST;
    end
    else if (wr_en)
    begin
      case (addr8)
        `MPP_OFS_C_CFG: c_cfg <= pwdata[7:0];
        `MPP_OFS_C_DATA: c_data <= pwdata[7:0];
        `MPP_OFS_G_CFG: g_cfg <= pwdata[7:0];
        `MPP_OFS_G_DATA: g_data <= pwdata[7:0];
        `MPP_OFS_L_CFG: l_cfg <= pwdata[7:0];
        `MPP_OFS_L_DATA: l_data <= pwdata[7:0];
        `MPP_OFS_D_DATA: d_data <= pwdata[7:0];
        // pin and status offsets take no write and raise no error
        default: d_data <= d_data;
      endcase
    end
  end

  // mode request: write of one sets, exit event clears; write wins
  // detector starts at the synchroniser's reset level: a pin already
  // high at release counts as one wake edge
  assign g7_rise = rc_osc_option_i & g_sync[7] & ~g7_prev;
  always @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      stop_req <= 1'b0;
      idle_req <= 1'b0;
      g7_prev <= 1'b0;
    end
    else
    begin
      g7_prev <= g_sync[7];
      if (wr_en && addr8 == `MPP_OFS_G_DATA &&
          pwdata[`MPP_G_STOP_BIT])
        stop_req <= 1'b1;
      else if (stop_exit_i || g7_rise)
        stop_req <= 1'b0;
      if (wr_en && addr8 == `MPP_OFS_G_DATA &&
          pwdata[`MPP_G_IDLE_BIT])
        idle_req <= 1'b1;
      else if (idle_exit_i)
        idle_req <= 1'b0;
    end
  end

  always @*
  begin
    next_rdata = 8'h00;
    next_err = 1'b0;
    case (addr8)
      `MPP_OFS_C_CFG: next_rdata = c_cfg;
      `MPP_OFS_C_DATA: next_rdata = c_data;
      `MPP_OFS_C_PIN: next_rdata = c_sync;
      `MPP_OFS_G_CFG: next_rdata = g_cfg;
      `MPP_OFS_G_DATA: next_rdata = {2'b00, g_data[5:0]};
      `MPP_OFS_G_PIN: next_rdata = g_sync;
      `MPP_OFS_L_CFG: next_rdata = l_cfg;
      `MPP_OFS_L_DATA: next_rdata = l_data;
      `MPP_OFS_L_PIN: next_rdata = l_sync;
      `MPP_OFS_D_DATA: next_rdata = d_data;
      `MPP_OFS_I_PIN: next_rdata = i_sync;
      `MPP_OFS_STATUS: next_rdata = {6'h00, idle_req, stop_req};
      default: next_err = 1'b1;
    endcase
  end

  // read data registered in setup, so it stands during access
  always @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & next_err;
      // writes and refused offsets leave zero on the read bus
      if (psel && !penable)
      begin
        if (rd_en)
          prdata <= {24'h000000, next_rdata};
        else
          prdata <= 32'h00000000;
      end
    end
  end

  // pin drive; d and g1 follow reset asynchronously
  always @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      port_c_out_o <= 8'h00;
      port_c_oe_n_o <= 8'hFF;
      port_c_pullup_o <= 8'h00;
      port_g_out_o <= 8'h00;
      port_g_oe_n_o <= 8'hFD;
      port_g_pullup_o <= 8'h00;
      port_l_out_o <= 8'h00;
      port_l_oe_n_o <= 8'hFF;
      port_l_pullup_o <= 8'h00;
      port_d_o <= `MPP_D_RST;
      analog_in_o <= 8'h00;
      stop_mode_o <= 1'b0;
      idle_mode_o <= 1'b0;
      serial_clock_alt_phase_o <= 1'b0;
      startup_delay_enable_o <= 1'b0;
      serial_data_in_o <= 1'b0;
      serial_clock_pin_in_o <= 1'b0;
      timer1_io_pin_in_o <= 1'b0;
      timer1_capture_pin_o <= 1'b0;
      external_interrupt_pin_o <= 1'b0;
      multi_input_wakeup_o <= 8'h00;
      timer2_first_input_o <= 1'b0;
      timer2_second_input_o <= 1'b0;
      timer3_first_input_o <= 1'b0;
      timer3_second_input_o <= 1'b0;
      stop_wake_o <= 1'b0;
    end
    else
    begin
      port_c_out_o <= c_out;
      port_c_oe_n_o <= c_oe_n;
      port_c_pullup_o <= c_pu;
      port_l_out_o <= l_out;
      port_l_oe_n_o <= l_oe_n;
      port_l_pullup_o <= l_pu;
      // g6 input only, g7 clock out or input, g1 error output
      port_g_out_o <= {oscillator_clock_input_i, g_out[6:2],
        supervisor_error_i, g_out[0]};
      port_g_oe_n_o <= {rc_osc_option_i, 1'b1, g_oe_n[5:2], 1'b0,
        g_oe_n[0]};
      port_g_pullup_o <= {2'b00, g_pu[5:2], 1'b0, g_pu[0]};
      port_d_o <= d_data;
      analog_in_o <= i_sync;
      stop_mode_o <= stop_req;
      idle_mode_o <= idle_req;
      serial_clock_alt_phase_o <= g_cfg[`MPP_G_ALTPH_BIT];
      startup_delay_enable_o <= g_cfg[`MPP_G_DLY_BIT] &
        rc_osc_option_i;
      serial_data_in_o <= g_sync[6];
      serial_clock_pin_in_o <= g_sync[5];
      timer1_io_pin_in_o <= g_sync[3];
      timer1_capture_pin_o <= g_sync[2];
      external_interrupt_pin_o <= g_sync[0];
      multi_input_wakeup_o <= l_sync;
      timer2_first_input_o <= l_sync[4];
      timer2_second_input_o <= l_sync[5];
      timer3_first_input_o <= l_sync[6];
      timer3_second_input_o <= l_sync[7];
      stop_wake_o <= g7_rise;
    end
  end
endmodule
`default_nettype wire

/* File: hw/mpp_sync.v */
// two-flop synchroniser for a bus of pin levels
// assumes pins are asynchronous to clk_sys_i
`timescale 1ns/1ps
`default_nettype none
module mpp_sync #(
  parameter W = 8
) (
  input wire clk_sys_i,
  input wire sys_rst_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] meta;
  reg [W-1:0] stable;
  always @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta <= {W{1'b0}};
      stable <= {W{1'b0}};
    end
    else
    begin
      meta <= async_i;
      stable <= meta;
    end
  end
  assign sync_o = stable;
endmodule
`default_nettype wire

/* File: verification/mcu_parallel_port_set_bench.sv */
// bench for the parallel port set over apb
// assumes pad models on ports c and l, bench drives g and i pins
`timescale 1ns/1ps
`include "mpp_consts.vh"
`default_nettype none
module mcu_parallel_port_set_bench;
  logic clk_sys_i = 0, sys_rst_i = 0, psel = 0, penable = 0, pwrite = 0;
  logic rc_osc_option_i = 1, oscillator_clock_input_i = 0, serr;
  logic supervisor_error_i = 0, stop_exit_i = 0, idle_exit_i = 0;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rdat;
  logic pready, pslverr, stop_mode_o, idle_mode_o, serial_clock_alt_phase_o;
  logic startup_delay_enable_o, serial_data_in_o, serial_clock_pin_in_o;
  logic timer1_io_pin_in_o, timer1_capture_pin_o, external_interrupt_pin_o;
  logic timer2_first_input_o, timer2_second_input_o, timer3_first_input_o;
  logic timer3_second_input_o, stop_wake_o;
  logic [7:0] port_c_in_i, port_c_out_o, port_c_oe_n_o, port_c_pullup_o;
  logic [7:0] port_g_in_i = 0, port_g_out_o, port_g_oe_n_o, port_g_pullup_o;
  logic [7:0] port_l_in_i, port_l_out_o, port_l_oe_n_o, port_l_pullup_o;
  logic [7:0] port_d_o, port_i_in_i = 0, analog_in_o, multi_input_wakeup_o;
  logic [7:0] c_ext = 0, c_en = 0, l_ext = 0, l_en = 0;
  integer error_cnt = 0, check_count = 0, cyc = 0, i;
  mpp_port_set u_dut (.*);
  mpp_pads u_pc (.clk_i(clk_sys_i), .out_i(port_c_out_o),
    .oe_n_i(port_c_oe_n_o), .pullup_i(port_c_pullup_o), .ext_i(c_ext),
    .ext_en_i(c_en), .pin_o(port_c_in_i));
  mpp_pads u_pl (.clk_i(clk_sys_i), .out_i(port_l_out_o),
    .oe_n_i(port_l_oe_n_o), .pullup_i(port_l_pullup_o), .ext_i(l_ext),
    .ext_en_i(l_en), .pin_o(port_l_in_i));
  always #25 clk_sys_i = ~clk_sys_i;
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      $display("MISMATCH %0t: timeout", $time);
      finish_test;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // an edge passes first so back-to-back calls never re-drive psel at once
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h000000, a};
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk(rdat, exp);
  endtask
  initial
  begin
    // raised as an event so the asynchronous reset acts before any edge
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk(32'(port_d_o), 32'hFF);
    chk(32'(port_g_oe_n_o), 32'hFD);
    repeat (17) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd(`MPP_OFS_C_CFG, 32'h00);
    rd(`MPP_OFS_L_DATA, 32'h00);
    c_ext <= 8'h01;
    c_en <= 8'h03;
    xfer(1'b1, `MPP_OFS_C_CFG, 32'hF0);
    xfer(1'b1, `MPP_OFS_C_DATA, 32'hCC);
    repeat (5) @(posedge clk_sys_i);
    chk(32'({port_c_oe_n_o, port_c_pullup_o}), 32'h0F0C);
    chk(32'(port_c_out_o[7:4]), 32'hC);
    rd(`MPP_OFS_C_PIN, 32'hCD);
    rd(`MPP_OFS_C_DATA, 32'hCC);
    xfer(1'b0, 8'h30, 32'h0);
    chk(32'(serr), 32'h1);
    xfer(1'b1, 8'h30, 32'h000000FF);
    chk(32'(serr), 32'h1);
    $display("test pin modes done");
    xfer(1'b1, `MPP_OFS_G_DATA, 32'hC0);
    repeat (3) @(posedge clk_sys_i);
    chk(32'({stop_mode_o, idle_mode_o}), 32'h3);
    rd(`MPP_OFS_G_DATA, 32'h00);
    rd(`MPP_OFS_STATUS, 32'h03);
    idle_exit_i <= 1'b1;
    @(posedge clk_sys_i);
    idle_exit_i <= 1'b0;
    port_g_in_i <= 8'h80;
    for (i = 0; i < 8 && stop_wake_o !== 1'b1; i++) @(posedge clk_sys_i);
    chk(32'(stop_wake_o), 32'h1);
    repeat (3) @(posedge clk_sys_i);
    chk(32'({stop_mode_o, idle_mode_o}), 32'h0);
    xfer(1'b1, `MPP_OFS_G_DATA, 32'h00000080);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(stop_mode_o), 32'h1);
    stop_exit_i <= 1'b1;
    @(posedge clk_sys_i);
    stop_exit_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk(32'(stop_mode_o), 32'h0);
    $display("test power modes done");
    supervisor_error_i <= 1'b1;
    xfer(1'b1, `MPP_OFS_G_CFG, 32'hFF);
    repeat (3) @(posedge clk_sys_i);
    chk(32'({serial_clock_alt_phase_o, startup_delay_enable_o}), 32'h3);
    chk(32'({port_g_oe_n_o[6], port_g_oe_n_o[1]}), 32'h2);
    chk(32'(port_g_out_o[1]), 32'h1);
    rd(`MPP_OFS_G_CFG, 32'hFF);
    rc_osc_option_i <= 1'b0;
    oscillator_clock_input_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk(32'({port_g_oe_n_o[7], port_g_out_o[7], startup_delay_enable_o}),
      32'h2);
    xfer(1'b1, `MPP_OFS_G_CFG, 32'h00000000);
    xfer(1'b1, `MPP_OFS_G_DATA, 32'h0000003D);
    repeat (2) @(posedge clk_sys_i);
    chk(32'({port_g_oe_n_o, port_g_pullup_o, port_g_out_o}),
      32'h007D3DBF);
    $display("test port g done");
    port_g_in_i <= 8'h4D;
    l_ext <= 8'hA5;
    l_en <= 8'hFF;
    port_i_in_i <= 8'h3C;
    repeat (6) @(posedge clk_sys_i);
    chk(32'({serial_data_in_o, serial_clock_pin_in_o, timer1_io_pin_in_o,
      timer1_capture_pin_o, external_interrupt_pin_o}), 32'h17);
    chk(32'(multi_input_wakeup_o), 32'hA5);
    chk(32'({timer3_second_input_o, timer3_first_input_o,
      timer2_second_input_o, timer2_first_input_o}), 32'hA);
    chk(32'(analog_in_o), 32'h3C);
    rd(`MPP_OFS_I_PIN, 32'h3C);
    rd(`MPP_OFS_L_PIN, 32'hA5);
    xfer(1'b1, `MPP_OFS_L_CFG, 32'h0000000F);
    xfer(1'b1, `MPP_OFS_L_DATA, 32'h00000036);
    repeat (5) @(posedge clk_sys_i);
    chk(32'({port_l_oe_n_o, port_l_pullup_o, port_l_out_o}),
      32'h00F03036);
    rd(`MPP_OFS_L_PIN, 32'hA6);
    xfer(1'b1, `MPP_OFS_D_DATA, 32'h5A);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(port_d_o), 32'h5A);
    sys_rst_i <= 1'b1;
    @(posedge clk_sys_i);
    chk(32'({port_d_o, port_c_oe_n_o}), 32'hFFFF);
    sys_rst_i <= 1'b0;
    rd(`MPP_OFS_D_DATA, 32'hFF);
    rd(`MPP_OFS_L_CFG, 32'h00);
    rd(`MPP_OFS_STATUS, 32'h00);
    $display("test inputs and reset done");
    finish_test;
  end
endmodule
`default_nettype wire

/* File: verification/mpp_chk.sv */
// checker for the parallel port set
// assumes bound to mpp_port_set, offsets from mpp_consts.vh
`timescale 1ns/1ps
`include "mpp_consts.vh"
`default_nettype none
module mpp_chk (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rc_osc_option_i,
  input wire logic [7:0] port_c_oe_n_o,
  input wire logic [7:0] port_c_pullup_o,
  input wire logic [7:0] port_g_oe_n_o,
  input wire logic [7:0] port_d_o,
  input wire logic stop_mode_o,
  input wire logic idle_mode_o,
  input wire logic stop_wake_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  AST_PREADY:
    assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  AST_ERR:
    assert property (psel && !penable && paddr[7:0] > `MPP_OFS_STATUS
      |=> pslverr && prdata == 32'h00000000) else $error("bad offset");
  AST_GRD:
    assert property (psel && !penable && !pwrite
      && paddr[7:0] == `MPP_OFS_G_DATA |=> prdata[7:6] == 2'b00)
    else $error("g data top bits not zero");
  AST_D_RST:
    assert property (disable iff (1'b0) sys_rst_i |-> port_d_o == 8'hFF)
    else $error("port d not high in reset");
  AST_G_FIX:
    assert property (!port_g_oe_n_o[1] && port_g_oe_n_o[6])
    else $error("g1 or g6 direction wrong");
  AST_PULL:
    assert property ((port_c_pullup_o & ~port_c_oe_n_o) == 8'h00)
    else $error("pull-up while driving");
  AST_CMODE:
    assert property (psel && penable && pwrite
      && paddr[7:0] == `MPP_OFS_C_CFG
      |=> ##1 port_c_oe_n_o == ~$past(pwdata[7:0], 2))
    else $error("c direction not from config");
  AST_STOP:
    assert property (psel && penable && pwrite
      && paddr[7:0] == `MPP_OFS_G_DATA && pwdata[7] |-> ##[1:2] stop_mode_o)
    else $error("stop not entered");
  AST_IDLE:
    assert property (psel && penable && pwrite
      && paddr[7:0] == `MPP_OFS_G_DATA && pwdata[6] |-> ##[1:2] idle_mode_o)
    else $error("idle not entered");
  AST_WAKE:
    assert property (stop_wake_o |-> rc_osc_option_i ##1 !stop_wake_o)
    else $error("wake pulse wrong");
endmodule
bind mpp_port_set mpp_chk u_chk (.clk_sys_i, .sys_rst_i, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rc_osc_option_i,
  .port_c_oe_n_o, .port_c_pullup_o, .port_g_oe_n_o, .port_d_o, .stop_mode_o,
  .idle_mode_o, .stop_wake_o);
`default_nettype wire

/* File: verification/mpp_pads.sv */
// pad and load model for one bidirectional port
// assumes far side drives only bits enabled by ext_en_i
`timescale 1ns/1ps
`default_nettype none
module mpp_pads (
  input wire logic clk_i,
  input wire logic [7:0] out_i,
  input wire logic [7:0] oe_n_i,
  input wire logic [7:0] pullup_i,
  input wire logic [7:0] ext_i,
  input wire logic [7:0] ext_en_i,
  output var logic [7:0] pin_o
);
  initial pin_o = 8'h00;
  // floating bits toggle so a stale level never reads as valid
  always @(posedge clk_i)
    pin_o <= ~oe_n_i & out_i | oe_n_i & (ext_en_i & ext_i
      | ~ext_en_i & (pullup_i | ~pin_o));
endmodule
`default_nettype wire
